// >>> design/kbd_host_map.vh
`ifndef KBD_HOST_MAP_VH
`define KBD_HOST_MAP_VH
// Status bit positions
`define ST_OBF 0
`define ST_IBF 1
`define ST_SYS 2
`define ST_CMD 3
`define ST_UNINH 4
`define ST_B5 5
`define ST_B6 6
`define ST_PAR 7
// Command byte bit positions and reset value
`define CB_OBF_EN 0
`define CB_AUX_EN 1
`define CB_SYS 2
`define CB_INH_OVR 3
`define CB_KBD_DIS 4
`define CB_B5 5
`define CB_XLATE 6
`define CB_RESET 8'h40
// Command codes
`define C_RD_CB 8'h20
`define C_WR_CB 8'h60
`define C_VER 8'hA1
`define C_PASS 8'hA4
`define C_AUX_DIS 8'hA7
`define C_AUX_ENA 8'hA8
`define C_AUX_TEST 8'hA9
`define C_SELF 8'hAA
`define C_KBD_TEST 8'hAB
`define C_KBD_DIS 8'hAD
`define C_KBD_ENA 8'hAE
`define C_VER2 8'hAF
`define C_RD_IN 8'hC0
`define C_POLL_LO 8'hC1
`define C_POLL_HI 8'hC2
`define C_MODE 8'hCA
`define C_RD_OUT 8'hD0
`define C_WR_OUT 8'hD1
`define C_WR_KOB 8'hD2
`define C_WR_AOB 8'hD3
`define C_WR_AUX 8'hD4
`define C_RD_TEST 8'hE0
// Answers
`define R_SELF_OK 8'h55
`define R_TEST_OK 8'h00
`define R_PASS 8'hF1
// Reset values of ports
`define IN_RESET 8'hFF
`define OUT_RESET 8'hFF
// Timing: 6 us pulse at 50 MHz, also 6 us strap delay
`define PULSE_NS 6000
`define CLK_NS 20
`define PULSE_CYC (`PULSE_NS / `CLK_NS)
`endif

// >>> design/sync_fifo.v
`timescale 1ns/10ps
module sync_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // --------------------------------
  // Flags and handshakes
  // --------------------------------
  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem[rdPtr_reg];

  // Storage has no reset; only pointers and fill count do
  always @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers and fill count
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (push & !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// >>> design/kbd_host_command_unit.v
// Overview of operation
// - Select high: read gives status, write gives a command.
// - Status: bit0 output full, bit1 input full, bit3 last write command.
// - Status bit4 is 0 while keyboard inhibited, 1 otherwise.
// - Bits 5/6: timeouts in legacy; aux full and any timeout in aux mode.
// - Status bit7 set when last serial byte showed even parity.
// - Status bit2 mirrors command byte bit2, zero after power-on.
// - Command byte bits 0/1 raise keyboard/aux interrupt on buffer load.
// - Command byte bit3 overrides inhibit; bit4 disables keyboard.
// - Bit5: legacy original-keyboard checking at 0; aux mode disables pointer.
// - Command byte bit6 defaults to 1 enabling translation; bit7 reserved.
// - 20h returns command byte; 60h stores next data byte into it.
// - AAh returns 55h, A9h/ABh return 00h, A4h returns F1.
// - Aux mode: A7h sets bit5 and out bit3; A8h clears both.
// - ADh disables, AEh enables the keyboard interface.
// - B0h-BFh drive selected pin; 9xh writes input-port bits 3-0.
// - C0h returns input port; C1h/C2h copy pins into status 5-7.
// - CAh returns mode on bit0; E0h returns test inputs.
// - D0h returns output port; D1h writes next data byte there.
// - D2h/D3h place next data byte in buffer as keyboard/aux.
// - D4h sends next data byte to the pointer instead.
// - Exh sets output-port bits 3-1 from command bits 3-1.
// - Fxh pulses selected output-port bits 3-0 low for 6 us.
// - Data-port writes go to the keyboard serial interface.
// - After reset, test input one and input bit0 both low select aux mode.
`timescale 1ns/10ps
`include "kbd_host_map.vh"
module kbd_host_command_unit (
  input wire sys_clk,
  input wire rst_n,
  input wire chipSel_n,
  input wire rd_n,
  input wire wr_n,
  input wire cmd_data_select,
  input wire [7:0] hostDataIn,
  output reg [7:0] hostDataOut,
  output wire hostDataOe,
  input wire [7:0] input_port_pins,
  output wire [7:0] input_port_bits,
  output wire [7:0] output_port_bits,
  output wire kbd_irq_out,
  output wire aux_irq_out,
  input wire test_input_zero,
  input wire test_input_one,
  input wire keylockIn_n,
  output wire [7:0] serialTxData,
  output wire serialTxAux,
  output wire serialTxValid,
  input wire serialTxReady,
  input wire [7:0] serialRxData,
  input wire serialRxAux,
  input wire serialRxValid,
  output wire serialRxReady,
  input wire rxParityEven,
  input wire txTimeout,
  input wire rxTimeout,
  input wire errorStrobe,
  output wire translateOn,
  output wire legacyCheck,
  output wire kbdEnable,
  output wire auxEnable
);
  // Pending data-byte destinations
  localparam DST_KBD = 3'd0;
  localparam DST_CB = 3'd1;
  localparam DST_OUT = 3'd2;
  localparam DST_KOB = 3'd3;
  localparam DST_AOB = 3'd4;
  localparam DST_AUX = 3'd5;

  reg [7:0] statusHi_reg;
  reg [7:0] cmdByte_reg;
  reg [7:0] inPort_reg;
  reg [7:0] outPort_reg;
  reg [7:0] outBuf_reg;
  reg obf_reg;
  reg auxObf_reg;
  reg ibf_reg;
  reg lastCmd_reg;
  reg [7:0] inBuf_reg;
  reg [2:0] dest_reg;
  reg auxMode_reg;
  reg strapDone_reg;
  reg [8:0] timer_reg;
  reg [3:0] pulseMask_reg;
  reg rdPrev_reg;
  reg wrPrev_reg;
  reg kbdDis_reg;
  reg txLoad;
  reg [8:0] txWord;
  reg obLoad;
  reg [7:0] obValue;
  reg obAux;
  wire rdStrobe;
  wire wrStrobe;
  wire [7:0] statusByte;
  wire fifoReady;
  wire rxTake;

  // --------------------------------
  // Host bus strobes
  // --------------------------------
  // Strobes act on their trailing edge so the data has settled
  assign rdStrobe = !rdPrev_reg & (rd_n | chipSel_n);
  assign wrStrobe = !wrPrev_reg & (wr_n | chipSel_n);
  assign hostDataOe = !chipSel_n & !rd_n;

  assign statusByte = {statusHi_reg[7:5], (cmdByte_reg[`CB_INH_OVR] | keylockIn_n),
    lastCmd_reg, cmdByte_reg[`CB_SYS], ibf_reg, obf_reg};

  // Output port shows pulses low where Fxh asked
  assign output_port_bits = outPort_reg & ~{4'h0, pulseMask_reg};
  assign input_port_bits = inPort_reg;
  // interrupt pins gate the full flags by the enables
  assign kbd_irq_out = obf_reg & !auxObf_reg & cmdByte_reg[`CB_OBF_EN];
  assign aux_irq_out = auxObf_reg & cmdByte_reg[`CB_AUX_EN];
  assign kbdEnable = !cmdByte_reg[`CB_KBD_DIS] & !kbdDis_reg;
  assign auxEnable = auxMode_reg & !cmdByte_reg[`CB_B5];
  assign legacyCheck = !auxMode_reg & !cmdByte_reg[`CB_B5];
  assign translateOn = cmdByte_reg[`CB_XLATE];
  // Received bytes enter only with both buffers idle; no loop through the decoder
  assign serialRxReady = !obf_reg & !ibf_reg;
  assign rxTake = serialRxValid & serialRxReady;

  // --------------------------------
  // Transmit FIFO toward the serial engines
  // --------------------------------
  sync_fifo #(.WIDTH(9), .DEPTH(16), .AW(4)) txFifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .inValid(txLoad),
    .inReady(fifoReady),
    .inData(txWord),
    .outValid(serialTxValid),
    .outReady(serialTxReady),
    .outData({serialTxAux, serialTxData})
  );

  // Read mux registered on the read strobe leading edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostDataOut <= 8'h00;
    end else if (!chipSel_n & !rd_n & rdPrev_reg) begin
      hostDataOut <= cmd_data_select ? statusByte : outBuf_reg;
    end
  end

  // --------------------------------
  // Command decode (combinational)
  // --------------------------------
  always @* begin
    txLoad = 1'b0;
    txWord = 9'h000;
    obLoad = 1'b0;
    obValue = 8'h00;
    obAux = 1'b0;
    if (ibf_reg && strapDone_reg && !lastCmd_reg) begin
      case (dest_reg)
        DST_KBD: begin
          txLoad = 1'b1;
          txWord = {1'b0, inBuf_reg};
        end
        DST_AUX: begin
          txLoad = 1'b1;
          txWord = {1'b1, inBuf_reg};
        end
        DST_KOB: begin
          obLoad = 1'b1;
          obValue = inBuf_reg;
        end
        DST_AOB: begin
          obLoad = 1'b1;
          obValue = inBuf_reg;
          obAux = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (ibf_reg && strapDone_reg) begin
      case (inBuf_reg)
        `C_RD_CB: begin
          obLoad = 1'b1;
          obValue = cmdByte_reg;
        end
        `C_PASS: begin
          obLoad = 1'b1;
          obValue = `R_PASS;
        end
        `C_SELF: begin
          obLoad = 1'b1;
          obValue = `R_SELF_OK;
        end
        `C_AUX_TEST, `C_KBD_TEST: begin
          obLoad = 1'b1;
          obValue = `R_TEST_OK;
        end
        `C_RD_IN: begin
          obLoad = 1'b1;
          obValue = input_port_pins & inPort_reg;
        end
        `C_MODE: begin
          obLoad = 1'b1;
          obValue = {7'h00, auxMode_reg};
        end
        `C_RD_TEST: begin
          obLoad = 1'b1;
          obValue = {6'h00, test_input_one, test_input_zero};
        end
        `C_RD_OUT: begin
          obLoad = 1'b1;
          obValue = output_port_bits;
        end
        default: begin
        end
      endcase
    end
    if (rxTake) begin
      obLoad = 1'b1;
      obValue = serialRxData;
      obAux = serialRxAux;
    end
  end

  // --------------------------------
  // Controller state
  // --------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPrev_reg <= 1'b1;
      wrPrev_reg <= 1'b1;
      cmdByte_reg <= `CB_RESET;
      statusHi_reg <= 8'h00;
      inPort_reg <= `IN_RESET;
      outPort_reg <= `OUT_RESET;
      outBuf_reg <= 8'h00;
      obf_reg <= 1'b0;
      auxObf_reg <= 1'b0;
      ibf_reg <= 1'b0;
      lastCmd_reg <= 1'b0;
      inBuf_reg <= 8'h00;
      dest_reg <= DST_KBD;
      auxMode_reg <= 1'b0;
      strapDone_reg <= 1'b0;
      timer_reg <= 9'd0;
      pulseMask_reg <= 4'h0;
      kbdDis_reg <= 1'b0;
    end else begin
      rdPrev_reg <= rd_n | chipSel_n;
      wrPrev_reg <= wr_n | chipSel_n;
      // Strap sampled once, 6 us after reset release
      if (!strapDone_reg) begin
        timer_reg <= timer_reg + 9'd1;
        if (timer_reg == (`PULSE_CYC - 1)) begin
          strapDone_reg <= 1'b1;
          auxMode_reg <= !test_input_one & !input_port_pins[0];
          timer_reg <= 9'd0;
        end
      end else if (pulseMask_reg != 4'h0) begin
        timer_reg <= timer_reg + 9'd1;
        if (timer_reg == (`PULSE_CYC - 1)) begin
          pulseMask_reg <= 4'h0;
          timer_reg <= 9'd0;
        end
      end
      // Host reads of the data port empty the output buffer
      if (rdStrobe & !cmd_data_select) begin
        obf_reg <= 1'b0;
        auxObf_reg <= 1'b0;
      end
      // Serial error capture
      if (errorStrobe) begin
        statusHi_reg[`ST_PAR] <= rxParityEven;
        if (auxMode_reg) begin
          statusHi_reg[`ST_B6] <= txTimeout | rxTimeout;
        end else begin
          statusHi_reg[`ST_B5] <= txTimeout;
          statusHi_reg[`ST_B6] <= rxTimeout;
        end
      end
      if (obLoad) begin
        outBuf_reg <= obValue;
        obf_reg <= 1'b1;
        auxObf_reg <= obAux;
        if (auxMode_reg) begin
          statusHi_reg[`ST_B5] <= obAux;
        end
      end else if (auxMode_reg & rdStrobe & !cmd_data_select) begin
        statusHi_reg[`ST_B5] <= 1'b0;
      end
      // Accept the pending byte; data bytes stall while FIFO full
      if (ibf_reg & strapDone_reg & (fifoReady | !txLoad)) begin
        ibf_reg <= 1'b0;
        if (!lastCmd_reg) begin
          dest_reg <= DST_KBD;
          if (dest_reg == DST_CB) begin
            cmdByte_reg <= inBuf_reg & 8'h7F;
          end
          if (dest_reg == DST_OUT) begin
            outPort_reg <= inBuf_reg;
          end
        end else begin
          dest_reg <= DST_KBD;
          case (inBuf_reg[7:4])
            4'h6: begin
              if (inBuf_reg == `C_WR_CB) begin
                dest_reg <= DST_CB;
              end
            end
            4'h9: begin
              inPort_reg[3:0] <= inBuf_reg[3:0];
            end
            4'hA: begin
              if (inBuf_reg == `C_AUX_DIS && auxMode_reg) begin
                cmdByte_reg[`CB_B5] <= 1'b1;
                outPort_reg[3] <= 1'b1;
              end
              if (inBuf_reg == `C_AUX_ENA && auxMode_reg) begin
                cmdByte_reg[`CB_B5] <= 1'b0;
                outPort_reg[3] <= 1'b0;
              end
              if (inBuf_reg == `C_KBD_DIS) begin
                kbdDis_reg <= 1'b1;
              end
              if (inBuf_reg == `C_KBD_ENA) begin
                kbdDis_reg <= 1'b0;
              end
            end
            4'hB: begin
              case (inBuf_reg[2:0])
                3'd4: outPort_reg[2] <= inBuf_reg[3];
                3'd5: outPort_reg[3] <= inBuf_reg[3];
                3'd6: inPort_reg[4] <= inBuf_reg[3];
                3'd7: inPort_reg[5] <= inBuf_reg[3];
                default: inPort_reg[inBuf_reg[1:0]] <= inBuf_reg[3];
              endcase
            end
            4'hC: begin
              if (inBuf_reg == `C_POLL_LO) begin
                statusHi_reg[7:5] <= input_port_pins[3:1];
              end
              if (inBuf_reg == `C_POLL_HI) begin
                statusHi_reg[7:5] <= input_port_pins[7:5];
              end
            end
            4'hD: begin
              if (inBuf_reg == `C_WR_OUT) dest_reg <= DST_OUT;
              if (inBuf_reg == `C_WR_KOB) dest_reg <= DST_KOB;
              if (inBuf_reg == `C_WR_AOB) dest_reg <= DST_AOB;
              if (inBuf_reg == `C_WR_AUX) dest_reg <= DST_AUX;
            end
            4'hE: begin
              outPort_reg[3:1] <= inBuf_reg[3:1];
            end
            4'hF: begin
              pulseMask_reg <= inBuf_reg[3:0];
              timer_reg <= 9'd0;
            end
            default: begin
            end
          endcase
        end
      end
      // New host write; set wins over the acceptance clear
      if (wrStrobe) begin
        ibf_reg <= 1'b1;
        inBuf_reg <= hostDataIn;
        lastCmd_reg <= cmd_data_select;
      end
    end
  end
endmodule

// >>> verification/kbd_host_checker_sva.sv
`timescale 1ns/10ps
module kbd_host_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire chipSel_n,
  input wire rd_n,
  input wire wr_n,
  input wire hostDataOe,
  input wire [7:0] output_port_bits,
  input wire kbd_irq_out,
  input wire aux_irq_out,
  input wire serialRxReady,
  input wire translateOn,
  input wire kbdEnable
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cbk @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_oe;
    hostDataOe == (!chipSel_n && !rd_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus drive outside read");
  property p_irqExcl;
    !(kbd_irq_out && aux_irq_out);
  endproperty
  a_irqExcl: assert property (p_irqExcl) else $error("both irqs high");
  property p_kbdStall;
    kbd_irq_out |-> !serialRxReady;
  endproperty
  a_kbdStall: assert property (p_kbdStall) else $error("rx taken while full");
  property p_auxStall;
    aux_irq_out |-> !serialRxReady;
  endproperty
  a_auxStall: assert property (p_auxStall) else $error("rx taken while aux full");
  property p_rstOut;
    $rose(rst_n) |-> output_port_bits == 8'hFF && translateOn && !kbd_irq_out;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("bad reset values");
  // Enable only moves a few cycles after a host write
  property p_kbdEn;
    $changed(kbdEnable) |-> (!$past(wr_n, 2) || !$past(wr_n, 3) || !$past(wr_n, 4)
      || !$past(wr_n, 5));
  endproperty
  a_kbdEn: assert property (p_kbdEn) else $error("enable moved without write");
  property p_xlate;
    $changed(translateOn) |-> (!$past(wr_n, 2) || !$past(wr_n, 3) || !$past(wr_n, 4)
      || !$past(wr_n, 5));
  endproperty
  a_xlate: assert property (p_xlate) else $error("translate moved without write");
  property p_pulse;
    $fell(output_port_bits[0]) |-> !output_port_bits[0] [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("port pulse too short");
endmodule
bind kbd_host_command_unit kbd_host_checker i_chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .chipSel_n(chipSel_n),
  .rd_n(rd_n),
  .wr_n(wr_n),
  .hostDataOe(hostDataOe),
  .output_port_bits(output_port_bits),
  .kbd_irq_out(kbd_irq_out),
  .aux_irq_out(aux_irq_out),
  .serialRxReady(serialRxReady),
  .translateOn(translateOn),
  .kbdEnable(kbdEnable)
);

// >>> verification/kbd_link_model.sv
`timescale 1ns/10ps
module kbd_link_model (
  input wire sys_clk,
  input wire rst_n,
  input wire stall,
  input wire errReq,
  input wire [7:0] serialTxData,
  input wire serialTxAux,
  input wire serialTxValid,
  output wire serialTxReady,
  output reg [7:0] serialRxData,
  output wire serialRxAux,
  output wire serialRxValid,
  output wire rxParityEven,
  output wire txTimeout,
  output wire rxTimeout,
  output wire errorStrobe,
  output reg [7:0] lastTx,
  output reg lastAux,
  output reg [7:0] txCount
);
  // ----------------------------------------
  // Serial side stand-in
  // ----------------------------------------
  // Never sends; idle data toggles so stale bytes cannot pass
  assign serialTxReady = !stall;
  assign serialRxValid = 1'b0;
  assign serialRxAux = serialRxData[0];
  assign rxParityEven = 1'b1;
  assign txTimeout = 1'b1;
  assign rxTimeout = 1'b1;
  assign errorStrobe = errReq;
  // Record each byte taken off the transmit queue
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialRxData <= 8'h5A;
      lastTx <= 8'h00;
      lastAux <= 1'b0;
      txCount <= 8'h00;
    end else begin
      serialRxData <= ~serialRxData;
      if (serialTxValid && serialTxReady) begin
        lastTx <= serialTxData;
        lastAux <= serialTxAux;
        txCount <= txCount + 8'h01;
      end
    end
  end
endmodule

// >>> verification/kbd_host_command_unit_bench.sv
`timescale 1ns/10ps
module kbd_host_command_unit_bench;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg chipSel_n = 1'b1;
  reg rd_n = 1'b1;
  reg wr_n = 1'b1;
  reg cmdSel = 1'b0;
  reg [7:0] wrData = 8'h00;
  reg [7:0] extPins = 8'hFF;
  reg keylock_n = 1'b1;
  reg testOne = 1'b1;
  wire legacyChk, auxEn;
  reg stall = 1'b0;
  reg errReq = 1'b0;
  reg [7:0] rd;
  wire [7:0] hostDataOut, inBits, outBits, txData, rxData, lastTx, txCount;
  wire hostDataOe, kbdIrq, auxIrq, txAux, txValid, txReady, rxAux, rxValid, rxReady;
  wire parEven, txTo, rxTo, errStb, lastAux, translateOn, kbdEnable;
  integer errors = 0;
  integer numChecks = 0;
  integer i;
  // ----------------------------------------
  // Design, far side and clock
  // ----------------------------------------
  kbd_host_command_unit i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .chipSel_n(chipSel_n), .rd_n(rd_n), .wr_n(wr_n),
    .cmd_data_select(cmdSel), .hostDataIn(wrData), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .input_port_pins(inBits & extPins), .input_port_bits(inBits),
    .output_port_bits(outBits), .kbd_irq_out(kbdIrq), .aux_irq_out(auxIrq),
    .test_input_zero(1'b0), .test_input_one(testOne), .keylockIn_n(keylock_n),
    .serialTxData(txData), .serialTxAux(txAux), .serialTxValid(txValid),
    .serialTxReady(txReady), .serialRxData(rxData), .serialRxAux(rxAux),
    .serialRxValid(rxValid), .serialRxReady(rxReady), .rxParityEven(parEven),
    .txTimeout(txTo), .rxTimeout(rxTo), .errorStrobe(errStb), .translateOn(translateOn),
    .legacyCheck(legacyChk), .kbdEnable(kbdEnable), .auxEnable(auxEn)
  );
  kbd_link_model i_link (
    .sys_clk(sys_clk), .rst_n(rst_n), .stall(stall), .errReq(errReq),
    .serialTxData(txData), .serialTxAux(txAux), .serialTxValid(txValid),
    .serialTxReady(txReady), .serialRxData(rxData), .serialRxAux(rxAux),
    .serialRxValid(rxValid), .rxParityEven(parEven), .txTimeout(txTo),
    .rxTimeout(rxTo), .errorStrobe(errStb), .lastTx(lastTx), .lastAux(lastAux),
    .txCount(txCount)
  );
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // Host bus tasks
  // ----------------------------------------
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Strobe held one cycle; settle time per hand-over latency
  task hwr(input a0, input [7:0] d);
    begin
      @(posedge sys_clk);
      chipSel_n <= 1'b0;
      wr_n <= 1'b0;
      cmdSel <= a0;
      wrData <= d;
      @(posedge sys_clk);
      chipSel_n <= 1'b1;
      wr_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task hrd(input a0);
    begin
      @(posedge sys_clk);
      chipSel_n <= 1'b0;
      rd_n <= 1'b0;
      cmdSel <= a0;
      repeat (2) @(posedge sys_clk);
      rd = hostDataOut;
      chipSel_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task cmdRes(input [7:0] c, input [7:0] exp);
    begin
      hwr(1'b1, c);
      hrd(1'b0);
      chk("answer", exp, rd);
    end
  endtask
  task rdSt(input [7:0] exp);
    begin
      hrd(1'b1);
      chk("status", exp, rd);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Whole run is near 1450 cycles
  initial begin
    repeat (6000) @(posedge sys_clk);
    errors = errors + 1;
    end_of_test;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (310) @(posedge sys_clk);
    rdSt(8'h10);
    cmdRes(8'h20, 8'h40);
    hwr(1'b1, 8'h60);
    hwr(1'b0, 8'h47);
    hwr(1'b1, 8'h20);
    rdSt(8'h1D);
    chk("kbdIrq", 8'h01, {7'h00, kbdIrq});
    hrd(1'b0);
    chk("cmdByte", 8'h47, rd);
    $display("test done: command byte");
    cmdRes(8'hAA, 8'h55);
    cmdRes(8'hA9, 8'h00);
    cmdRes(8'hAB, 8'h00);
    cmdRes(8'hA4, 8'hF1);
    cmdRes(8'hCA, 8'h00);
    cmdRes(8'hE0, 8'h02);
    hwr(1'b1, 8'hA7);
    cmdRes(8'h20, 8'h47);
    hwr(1'b1, 8'hAD);
    chk("kbdEn", 8'h00, {7'h00, kbdEnable});
    hwr(1'b1, 8'hAE);
    chk("kbdEn", 8'h01, {7'h00, kbdEnable});
    $display("test done: fixed answers");
    hwr(1'b1, 8'hB0);
    chk("inPort", 8'hFE, inBits);
    cmdRes(8'hC0, 8'hFE);
    hwr(1'b1, 8'hB8);
    hwr(1'b1, 8'h95);
    chk("inPort", 8'hF5, inBits);
    hwr(1'b1, 8'hD1);
    hwr(1'b0, 8'hA5);
    cmdRes(8'hD0, 8'hA5);
    hwr(1'b1, 8'hB4);
    chk("outPort", 8'hA1, outBits);
    hwr(1'b1, 8'hE2);
    chk("outPort", 8'hA3, outBits);
    hwr(1'b1, 8'hF1);
    chk("pulse", 8'hA2, outBits);
    repeat (290) @(posedge sys_clk);
    chk("pulse", 8'hA2, outBits);
    repeat (10) @(posedge sys_clk);
    chk("pulse", 8'hA3, outBits);
    $display("test done: ports");
    // Far side stalls: 16 queued, the 17th waits in the input buffer
    stall <= 1'b1;
    for (i = 0; i < 17; i = i + 1)
      hwr(1'b0, i[7:0]);
    rdSt(8'h16);
    stall <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk("txCount", 8'h11, txCount);
    chk("lastTx", 8'h10, lastTx);
    hwr(1'b1, 8'hD4);
    hwr(1'b0, 8'h22);
    repeat (10) @(posedge sys_clk);
    chk("auxTx", 8'h22, lastTx);
    chk("auxFlag", 8'h01, {7'h00, lastAux});
    $display("test done: transmit queue");
    hwr(1'b1, 8'hD2);
    hwr(1'b0, 8'h33);
    chk("kbdIrq", 8'h01, {7'h00, kbdIrq});
    hrd(1'b0);
    chk("kbdData", 8'h33, rd);
    hwr(1'b1, 8'hD3);
    hwr(1'b0, 8'h44);
    chk("auxIrq", 8'h01, {7'h00, auxIrq});
    hrd(1'b0);
    chk("auxData", 8'h44, rd);
    @(posedge sys_clk);
    errReq <= 1'b1;
    @(posedge sys_clk);
    errReq <= 1'b0;
    rdSt(8'hF4);
    keylock_n <= 1'b0;
    rdSt(8'hE4);
    hwr(1'b1, 8'hC1);
    rdSt(8'h4C);
    hwr(1'b1, 8'h60);
    hwr(1'b0, 8'h07);
    chk("xlate", 8'h00, {7'h00, translateOn});
    $display("test done: buffer and status");
    // Second reset with both straps low selects aux mode
    testOne <= 1'b0;
    extPins <= 8'hFE;
    keylock_n <= 1'b1;
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (310) @(posedge sys_clk);
    cmdRes(8'hCA, 8'h01);
    chk("auxCtl", 8'h01, {6'h00, legacyChk, auxEn});
    hwr(1'b1, 8'hA8);
    chk("outPort", 8'hF7, outBits);
    hwr(1'b1, 8'hA7);
    chk("outPort", 8'hFF, outBits);
    chk("auxCtl", 8'h00, {6'h00, legacyChk, auxEn});
    cmdRes(8'h20, 8'h60);
    hwr(1'b1, 8'hD3);
    hwr(1'b0, 8'h55);
    rdSt(8'h31);
    hrd(1'b0);
    chk("auxData", 8'h55, rd);
    rdSt(8'h10);
    $display("test done: aux mode");
    end_of_test;
  end
endmodule
